// >>> shared/ssm_defines.svh
// Register offsets, field positions, reset values and counts of the status pin mapper
// Behaviour
// - Register 3 bits 12 to 7 route three indications onto two status pins.
// - Reference-select reads 0 for primary, 1 for secondary; routed by 3.12, 3.9.
// - Reference-loss reads 0 when present, 1 when lost; routed by 3.11, 3.8.
// - With register 4 bit 5 clear, loss indication is statically high.
// - Status register 21 bit 2 reads 0 while locked, 1 while unlocked.
// - Lock indication on a pin is inverted: high locked, low unlocked.
// - Several routing bits on one pin give the OR of their indications.
// - Both references stalled under auto switching: loss high, low only at count 511, 1 of 512.
// - Lock detector counts slips, flags unlock past a threshold, resets counter.
`ifndef SSM_DEFINES_SVH
`define SSM_DEFINES_SVH
`define SSM_REG_ROUTING 5'h03
`define SSM_REG_INPUT_CFG 5'h04
`define SSM_REG_STATUS 5'h15
`define SSM_ROUTING_RESET 16'h0000
`define SSM_INPUT_CFG_RESET 16'h0020
`define SSM_BIT_P0_SEL 12
`define SSM_BIT_P0_LOSS 11
`define SSM_BIT_P0_UNLOCK 10
`define SSM_BIT_P1_SEL 9
`define SSM_BIT_P1_LOSS 8
`define SSM_BIT_P1_UNLOCK 7
`define SSM_BIT_SEC_EN 5
`define SSM_BIT_AUTO_SW 6
`define SSM_BIT_ST_SEL 0
`define SSM_BIT_ST_LOSS 1
`define SSM_BIT_ST_UNLOCK 2
`define SSM_SLIP_LIMIT 8
`define SSM_RELOCK_PFD 1000
`define SSM_STUCK_PERIOD 512
`endif

// >>> shared/ssm_pkg.sv
// Types shared by the status pin mapper modules
`default_nettype none
package ssm_pkg;
   typedef enum logic [0:0] {
      SSM_LOCKED = 1'b0,
      SSM_UNLOCKED = 1'b1
   } ssm_lock_state_t;
endpackage : ssm_pkg
`default_nettype wire

// >>> hw/ssm_lock_detect.sv
// Digital lock detector counting cycle slips
`timescale 1ns/100ps
`default_nettype none
`include "ssm_defines.svh"
module ssm_lock_detect #(
   parameter int SLIP_LIMIT = `SSM_SLIP_LIMIT,
   parameter int RELOCK_PFD = `SSM_RELOCK_PFD
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic slip_evt,
   input wire logic pfd_evt,
   output logic unlock
);
   ssm_pkg::ssm_lock_state_t state_reg, state_next;
   logic [11:0] slip_cnt_reg, slip_cnt_next;
   logic [11:0] quiet_cnt_reg, quiet_cnt_next;

   // Slip counting and relock window
   always_comb begin
      state_next = state_reg;
      slip_cnt_next = slip_cnt_reg;
      quiet_cnt_next = quiet_cnt_reg;
      case (state_reg)
         ssm_pkg::SSM_LOCKED: begin
            if (slip_evt) begin
               if (slip_cnt_reg >= 12'(SLIP_LIMIT)) begin
                  state_next = ssm_pkg::SSM_UNLOCKED;
                  slip_cnt_next = 12'h000;
                  quiet_cnt_next = 12'h000;
               end else begin
                  slip_cnt_next = slip_cnt_reg + 12'h001;
               end
            end
         end
         ssm_pkg::SSM_UNLOCKED: begin
            if (slip_evt) begin
               quiet_cnt_next = 12'h000;
            end else if (pfd_evt) begin
               if (quiet_cnt_reg >= 12'(RELOCK_PFD - 1)) begin
                  state_next = ssm_pkg::SSM_LOCKED;
                  quiet_cnt_next = 12'h000;
               end else begin
                  quiet_cnt_next = quiet_cnt_reg + 12'h001;
               end
            end
         end
         default: begin
            state_next = ssm_pkg::SSM_UNLOCKED;
            slip_cnt_next = 12'h000;
            quiet_cnt_next = 12'h000;
         end
      endcase
   end

   // State registers
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_reg <= ssm_pkg::SSM_UNLOCKED;
         slip_cnt_reg <= 12'h000;
         quiet_cnt_reg <= 12'h000;
      end else begin
         state_reg <= state_next;
         slip_cnt_reg <= slip_cnt_next;
         quiet_cnt_reg <= quiet_cnt_next;
      end
   end

   assign unlock = (state_reg == ssm_pkg::SSM_UNLOCKED);

   // Unlock once the slip count passes the limit, counter cleared
   property p_slip_unlock;
      @(posedge sys_clk) disable iff (!rst_b)
      (state_reg == ssm_pkg::SSM_LOCKED && slip_evt && slip_cnt_reg >= 12'(SLIP_LIMIT))
      |=> (unlock && slip_cnt_reg == 12'h000);
   endproperty
   a_slip_unlock: assert property (p_slip_unlock) else $error("unlock not flagged");

   // No unlock below the limit
   property p_no_early_unlock;
      @(posedge sys_clk) disable iff (!rst_b)
      (state_reg == ssm_pkg::SSM_LOCKED && slip_cnt_reg < 12'(SLIP_LIMIT)) |=> !unlock;
   endproperty
   a_no_early_unlock: assert property (p_no_early_unlock) else $error("early unlock");

   c_relock: cover property (@(posedge sys_clk) disable iff (!rst_b) $fell(unlock));
endmodule : ssm_lock_detect
`default_nettype wire

// >>> hw/ssm_status_mapper.sv
// Status pin mapper: indication registers and routing onto two status pins
`timescale 1ns/100ps
`default_nettype none
`include "ssm_defines.svh"
module ssm_status_mapper #(
   parameter int SLIP_LIMIT = `SSM_SLIP_LIMIT,
   parameter int RELOCK_PFD = `SSM_RELOCK_PFD
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [4:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rd_valid,
   input wire logic ref_select_raw,
   input wire logic ref_loss_raw,
   input wire logic refs_stalled_raw,
   input wire logic los_stuck_raw,
   input wire logic slip_toggle_raw,
   input wire logic pfd_toggle_raw,
   output logic indicator_pin_zero,
   output logic indicator_pin_one
);
   localparam int NSYNC = 6;
   localparam logic [8:0] STUCK_LAST = 9'(`SSM_STUCK_PERIOD - 1);

   logic [NSYNC-1:0] raw_vec;
   logic [NSYNC-1:0] sync1_reg, sync2_reg;
   logic [15:0] routing_reg, routing_next;
   logic [15:0] input_cfg_reg, input_cfg_next;
   logic [15:0] rdata_reg, rdata_next;
   logic rd_valid_reg, rd_valid_next;
   logic pin0_reg, pin0_next;
   logic pin1_reg, pin1_next;
   logic slip_prev_reg, slip_prev_next;
   logic pfd_prev_reg, pfd_prev_next;
   logic [8:0] stuck_cnt_reg, stuck_cnt_next;
   logic sel_ind, loss_ind, unlock_ind, lock_ind;
   logic slip_evt, pfd_evt;
   logic ref_select_s, ref_loss_s, refs_stalled_s, los_stuck_s, slip_s, pfd_s;
   logic sec_en, auto_sw;

   assign raw_vec = {los_stuck_raw, refs_stalled_raw, ref_loss_raw,
                     ref_select_raw, slip_toggle_raw, pfd_toggle_raw};

   // Two-stage synchroniser per pin input
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= raw_vec[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   assign {los_stuck_s, refs_stalled_s, ref_loss_s, ref_select_s, slip_s, pfd_s} = sync2_reg;
   assign slip_evt = slip_s ^ slip_prev_reg;
   assign pfd_evt = pfd_s ^ pfd_prev_reg;
   assign sec_en = input_cfg_reg[`SSM_BIT_SEC_EN];
   assign auto_sw = input_cfg_reg[`SSM_BIT_AUTO_SW];

   ssm_lock_detect #(
      .SLIP_LIMIT(SLIP_LIMIT),
      .RELOCK_PFD(RELOCK_PFD)
   ) u_lock (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .slip_evt(slip_evt),
      .pfd_evt(pfd_evt),
      .unlock(unlock_ind)
   );

   // Live indications
   always_comb begin
      sel_ind = ref_select_s;
      lock_ind = !unlock_ind;
      if (!sec_en) begin
         loss_ind = 1'b1;
      end else if (auto_sw && refs_stalled_s) begin
         loss_ind = !(los_stuck_s && stuck_cnt_reg == STUCK_LAST);
      end else begin
         loss_ind = ref_loss_s;
      end
   end

   // Registers, readback, pin routing and toggle history
   always_comb begin
      routing_next = routing_reg;
      input_cfg_next = input_cfg_reg;
      rdata_next = rdata_reg;
      rd_valid_next = reg_rd_en;
      slip_prev_next = slip_s;
      pfd_prev_next = pfd_s;
      stuck_cnt_next = stuck_cnt_reg;
      if (pfd_evt) begin
         stuck_cnt_next = stuck_cnt_reg + 9'h001;
      end
      if (reg_wr_en) begin
         case (reg_addr)
            `SSM_REG_ROUTING: routing_next = reg_wdata;
            `SSM_REG_INPUT_CFG: input_cfg_next = reg_wdata;
            default: ; // Status and unmapped writes dropped
         endcase
      end
      if (reg_rd_en) begin
         case (reg_addr)
            `SSM_REG_ROUTING: rdata_next = routing_reg;
            `SSM_REG_INPUT_CFG: rdata_next = input_cfg_reg;
            `SSM_REG_STATUS: begin
               rdata_next = 16'h0000;
               rdata_next[`SSM_BIT_ST_SEL] = sel_ind;
               rdata_next[`SSM_BIT_ST_LOSS] = loss_ind;
               rdata_next[`SSM_BIT_ST_UNLOCK] = unlock_ind;
            end
            default: rdata_next = 16'h0000;
         endcase
      end
      // OR of every enabled indication per pin
      pin0_next = (routing_reg[`SSM_BIT_P0_SEL] & sel_ind)
                | (routing_reg[`SSM_BIT_P0_LOSS] & loss_ind)
                | (routing_reg[`SSM_BIT_P0_UNLOCK] & lock_ind);
      pin1_next = (routing_reg[`SSM_BIT_P1_SEL] & sel_ind)
                | (routing_reg[`SSM_BIT_P1_LOSS] & loss_ind)
                | (routing_reg[`SSM_BIT_P1_UNLOCK] & lock_ind);
   end

   // State registers
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         routing_reg <= `SSM_ROUTING_RESET;
         input_cfg_reg <= `SSM_INPUT_CFG_RESET;
         rdata_reg <= 16'h0000;
         rd_valid_reg <= 1'b0;
         pin0_reg <= 1'b0;
         pin1_reg <= 1'b0;
         slip_prev_reg <= 1'b0;
         pfd_prev_reg <= 1'b0;
         stuck_cnt_reg <= 9'h000;
      end else begin
         routing_reg <= routing_next;
         input_cfg_reg <= input_cfg_next;
         rdata_reg <= rdata_next;
         rd_valid_reg <= rd_valid_next;
         pin0_reg <= pin0_next;
         pin1_reg <= pin1_next;
         slip_prev_reg <= slip_prev_next;
         pfd_prev_reg <= pfd_prev_next;
         stuck_cnt_reg <= stuck_cnt_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rd_valid = rd_valid_reg;
   assign indicator_pin_zero = pin0_reg;
   assign indicator_pin_one = pin1_reg;

   // Pin zero follows the OR of its three routed indications
   property p_pin0_or;
      @(posedge sys_clk) disable iff (!rst_b)
      ##1 indicator_pin_zero == (($past(routing_reg[12]) & $past(sel_ind))
         | ($past(routing_reg[11]) & $past(loss_ind))
         | ($past(routing_reg[10]) & !$past(unlock_ind)));
   endproperty
   a_pin0_or: assert property (p_pin0_or) else $error("pin zero mismatch");

   // Select alone on pin one copies the select indication
   property p_pin1_sel;
      @(posedge sys_clk) disable iff (!rst_b)
      (routing_reg[9:7] == 3'b100) |=> (indicator_pin_one == $past(ref_select_s));
   endproperty
   a_pin1_sel: assert property (p_pin1_sel) else $error("pin one select mismatch");

   // Lock alone on pin zero is the inverse of the unlock flag
   property p_lock_inv;
      @(posedge sys_clk) disable iff (!rst_b)
      (routing_reg[12:10] == 3'b001) |=> (indicator_pin_zero != $past(unlock_ind));
   endproperty
   a_lock_inv: assert property (p_lock_inv) else $error("lock polarity wrong");

   // Secondary input off forces loss high on pin one
   property p_loss_static;
      @(posedge sys_clk) disable iff (!rst_b)
      (!sec_en && routing_reg[8]) |=> indicator_pin_one;
   endproperty
   a_loss_static: assert property (p_loss_static) else $error("loss not static high");

   // Loss alone on pin zero follows the reference when no override applies
   property p_loss_follow;
      @(posedge sys_clk) disable iff (!rst_b)
      (sec_en && !(auto_sw && refs_stalled_s) && routing_reg[12:10] == 3'b010)
      |=> (indicator_pin_zero == $past(ref_loss_s));
   endproperty
   a_loss_follow: assert property (p_loss_follow) else $error("loss mismatch");

   // Status read returns the live unlock flag one cycle later
   property p_status_unlock;
      @(posedge sys_clk) disable iff (!rst_b)
      (reg_rd_en && reg_addr == `SSM_REG_STATUS)
      |=> (reg_rd_valid && reg_rdata[2] == $past(unlock_ind) && reg_rdata[15:3] == 13'h0000);
   endproperty
   a_status_unlock: assert property (p_status_unlock) else $error("status bit wrong");

   // Writes to the status register change no stored state
   property p_status_ro;
      @(posedge sys_clk) disable iff (!rst_b)
      (reg_wr_en && reg_addr == `SSM_REG_STATUS)
      |=> ($stable(routing_reg) && $stable(input_cfg_reg));
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status write had effect");

   // Stalled loss dips low only at the last count of the period
   property p_stuck_dip;
      @(posedge sys_clk) disable iff (!rst_b)
      (sec_en && auto_sw && refs_stalled_s && !loss_ind)
      |-> (los_stuck_s && stuck_cnt_reg == STUCK_LAST);
   endproperty
   a_stuck_dip: assert property (p_stuck_dip) else $error("loss dip misplaced");

   // Routing write lands the next cycle
   property p_route_wr;
      @(posedge sys_clk) disable iff (!rst_b)
      (reg_wr_en && reg_addr == `SSM_REG_ROUTING) |=> (routing_reg == $past(reg_wdata));
   endproperty
   a_route_wr: assert property (p_route_wr) else $error("routing write lost");

   c_or_pin: cover property (@(posedge sys_clk) disable iff (!rst_b)
      routing_reg[11:10] == 2'b11 && indicator_pin_zero);
   c_unlock_read: cover property (@(posedge sys_clk) disable iff (!rst_b)
      reg_rd_valid && reg_rdata[2]);
   c_stuck: cover property (@(posedge sys_clk) disable iff (!rst_b)
      auto_sw && refs_stalled_s && !loss_ind);
endmodule : ssm_status_mapper
`default_nettype wire

// >>> sim/ssm_far_side.sv
// Far-side model: reference monitors and lock detector events
`timescale 1ns/100ps
`default_nettype none
module ssm_far_side (
   input wire logic sys_clk,
   output logic ref_select_raw,
   output logic ref_loss_raw,
   output logic refs_stalled_raw,
   output logic los_stuck_raw,
   output logic slip_toggle_raw,
   output logic pfd_toggle_raw
);
   // Quiet levels, toggles low through reset
   initial begin
      {ref_select_raw, ref_loss_raw, refs_stalled_raw, los_stuck_raw} = 4'h0;
      slip_toggle_raw = 1'b0;
      pfd_toggle_raw = 1'b0;
   end
   // Monitor levels, bit 1 is both references stalled
   task automatic set_ind(input logic [3:0] v);
      @(negedge sys_clk);
      {ref_select_raw, ref_loss_raw, refs_stalled_raw, los_stuck_raw} = v;
   endtask : set_ind
   // One toggle per event, spaced past the synchronisers
   task automatic send_events(input logic slip, input int n);
      repeat (n) begin
         repeat (4) @(negedge sys_clk);
         if (slip)
            slip_toggle_raw = ~slip_toggle_raw;
         else
            pfd_toggle_raw = ~pfd_toggle_raw;
      end
   endtask : send_events
endmodule : ssm_far_side
`default_nettype wire

// >>> sim/tb.sv
// Testbench for the status pin mapper
`timescale 1ns/100ps
`default_nettype none
`include "ssm_defines.svh"
module tb;
   localparam int SLIP_N = 2;
   localparam int RELOCK_N = 4;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic reg_rd_valid;
   logic ref_select_raw;
   logic ref_loss_raw;
   logic refs_stalled_raw;
   logic los_stuck_raw;
   logic slip_toggle_raw;
   logic pfd_toggle_raw;
   logic indicator_pin_zero;
   logic indicator_pin_one;
   logic ind_sel = 1'b0;
   logic ind_loss = 1'b0;
   logic locked = 1'b0;
   int fail_count = 0;
   int tests_run = 0;
   // Clock
   always #5 sys_clk = ~sys_clk;
   ssm_status_mapper #(.SLIP_LIMIT(SLIP_N), .RELOCK_PFD(RELOCK_N)) i_dut (
      .sys_clk, .rst_b, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
      .reg_rdata, .reg_rd_valid, .ref_select_raw, .ref_loss_raw,
      .refs_stalled_raw, .los_stuck_raw, .slip_toggle_raw, .pfd_toggle_raw,
      .indicator_pin_zero, .indicator_pin_one);
   ssm_far_side i_far (
      .sys_clk, .ref_select_raw, .ref_loss_raw, .refs_stalled_raw,
      .los_stuck_raw, .slip_toggle_raw, .pfd_toggle_raw);
   // Compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One-cycle write strobe
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
   endtask : wr
   // Read, answer one cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge sys_clk);
      reg_rd_en = 1'b0;
      check("read valid", {15'h0000, reg_rd_valid}, 16'h0001);
      check("read data", reg_rdata, exp);
   endtask : rd
   // Pins and status register against the tracked indications
   task automatic chk_state(input logic [15:0] r);
      logic [2:0] ind3;
      ind3 = {ind_sel, ind_loss, locked};
      repeat (6) @(negedge sys_clk);
      check("pins", {14'h0000, indicator_pin_one, indicator_pin_zero},
         {14'h0000, |(r[9:7] & ind3), |(r[12:10] & ind3)});
      rd(`SSM_REG_STATUS, {13'h0000, ~locked, ind_loss, ind_sel});
   endtask : chk_state
   task automatic t_reset;
      rd(`SSM_REG_ROUTING, `SSM_ROUTING_RESET);
      rd(`SSM_REG_INPUT_CFG, `SSM_INPUT_CFG_RESET);
      wr(5'h1F, 16'hFFFF);
      rd(5'h1F, 16'h0000);
   endtask : t_reset
   task automatic t_lock;
      wr(`SSM_REG_ROUTING, 16'h0480);
      i_far.send_events(1'b0, RELOCK_N - 1);
      chk_state(16'h0480);
      i_far.send_events(1'b0, 1);
      locked = 1'b1;
      chk_state(16'h0480);
      i_far.send_events(1'b1, SLIP_N);
      chk_state(16'h0480);
      i_far.send_events(1'b1, 1);
      locked = 1'b0;
      chk_state(16'h0480);
      i_far.send_events(1'b0, RELOCK_N);
      locked = 1'b1;
      chk_state(16'h0480);
   endtask : t_lock
   task automatic t_route(input logic [15:0] r);
      wr(`SSM_REG_ROUTING, r);
      rd(`SSM_REG_ROUTING, r);
      for (int v = 0; v < 4; v++) begin
         ind_sel = v[1];
         ind_loss = v[0];
         i_far.set_ind({ind_sel, ind_loss, 2'b00});
         chk_state(r);
      end
   endtask : t_route
   task automatic t_loss_cfg;
      wr(`SSM_REG_ROUTING, 16'h0800);
      ind_sel = 1'b0;
      ind_loss = 1'b1;
      i_far.set_ind(4'h0);
      wr(`SSM_REG_INPUT_CFG, 16'h0000);
      chk_state(16'h0800);
      wr(`SSM_REG_INPUT_CFG, 16'h0060);
      i_far.set_ind(4'h2);
      chk_state(16'h0800);
      i_far.set_ind(4'h3);
      // Stuck counter already holds the 2 * RELOCK_N events of t_lock
      i_far.send_events(1'b0, `SSM_STUCK_PERIOD - 1 - 2 * RELOCK_N);
      ind_loss = 1'b0;
      chk_state(16'h0800);
      i_far.send_events(1'b0, 1);
      ind_loss = 1'b1;
      chk_state(16'h0800);
      wr(`SSM_REG_INPUT_CFG, `SSM_INPUT_CFG_RESET);
      i_far.set_ind(4'h0);
      ind_loss = 1'b0;
      wr(`SSM_REG_STATUS, 16'hFFFF);
      chk_state(16'h0800);
      rd(`SSM_REG_ROUTING, 16'h0800);
   endtask : t_loss_cfg
   // Verdict and end of run
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   // Watchdog
   initial begin
      #300000;
      fail_count++;
      wrap_up();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_b = 1'b1;
      t_reset();
      t_lock();
      for (int b = 7; b <= 12; b++) begin
         t_route(16'h0001 << b);
      end
      t_route(16'h1900);
      t_loss_cfg();
      wrap_up();
   end
endmodule : tb
`default_nettype wire
